// file: inc/tpc_regs.svh
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// register byte addresses
`define TPC_ADDR_MODE 8'h00
`define TPC_ADDR_CYCLE 8'h04
`define TPC_ADDR_DUTY 8'h08
`define TPC_ADDR_CARR 8'h0c
`define TPC_ADDR_DIV 8'h10
`define TPC_ADDR_COUNT 8'h14
`define TPC_ADDR_FLAGS 8'h18

// mode register fields
`define TPC_MODE_RUN_BIT 0
`define TPC_MODE_OE_BIT 1
`define TPC_MODE_LEV_BIT 2
`define TPC_MODE_SEL_LSB 4
`define TPC_MODE_SEL_MSB 5

// carrier control register fields
`define TPC_CARR_SLAVE_BIT 0
`define TPC_CARR_MASTER_BIT 1
`define TPC_CARR_REMOTE_BIT 2

// reset values
`define TPC_RST_BYTE 8'h00

// timing, in count clock ticks
`define TPC_DUTY_LOAD_TICKS 2'd3
`define TPC_XFER_TICKS 2'd2

`endif

// file: inc/tpc_pkg.sv
package tpc_pkg;

  typedef enum logic [1:0] {
    TPC_MODE_INTERVAL = 2'h0,
    TPC_MODE_CARRIER = 2'h1,
    TPC_MODE_PWM = 2'h2,
    TPC_MODE_RSVD = 2'h3
  } tpc_mode_e;

  // gray along stop -> mask -> run
  typedef enum logic [1:0] {
    TPC_ST_STOP = 2'h0,
    TPC_ST_MASK = 2'h1,
    TPC_ST_RUN = 2'h3
  } tpc_run_e;

endpackage

// file: inc/tpc_car_if.sv
`timescale 1ns/1ns
`default_nettype none

interface tpc_car_if;
  logic count_tick;
  logic carrier_enable_master;
  logic carrier_enable_slave;
  logic synced_period_pulse;

  modport core (
    output count_tick,
    output carrier_enable_master,
    input carrier_enable_slave,
    input synced_period_pulse
  );

  modport ctl (
    input count_tick,
    input carrier_enable_master,
    output carrier_enable_slave,
    output synced_period_pulse
  );
endinterface

`default_nettype wire

// file: hdl/tpc_carrier_ctl.sv
`timescale 1ns/1ns
`default_nettype none
`include "tpc_regs.svh"

module tpc_carrier_ctl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // companion counter period event, asynchronous
  input wire logic companion_period_interrupt,
  // link to the timer core
  tpc_car_if.ctl cif
);

  logic sync_a;
  logic sync_b;
  logic [1:0] xfer_cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= companion_period_interrupt;
      sync_b <= sync_a;
    end
  end

  // resampled on the count clock so the transfer lines up with counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cif.synced_period_pulse <= 1'b0;
    end else if (cif.count_tick) begin
      cif.synced_period_pulse <= sync_b;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xfer_cnt <= 2'd0;
      cif.carrier_enable_slave <= 1'b0;
    end else if (cif.count_tick) begin
      if (xfer_cnt == `TPC_XFER_TICKS) begin
        cif.carrier_enable_slave <= cif.carrier_enable_master;
        xfer_cnt <= 2'd0;
      end else if (xfer_cnt != 2'd0) begin
        xfer_cnt <= xfer_cnt + 2'd1;
      end
      if (sync_b && !cif.synced_period_pulse) begin
        xfer_cnt <= 2'd1;
      end
    end
  end

endmodule

`default_nettype wire

// file: hdl/tpc_timer.sv
// Function
// - after enable the counter is compared with the cycle value first
// - pwm cycle match: clear counter, interrupt, output active, use duty
// - pwm duty match: output inactive, back to cycle, no clear or irq
// - pwm period is cycle plus one ticks, active width duty plus one
// - first count tick after enable is masked, output stays inactive
// - clearing run forces interrupt and output inactive, except a carrier pin held high by slave 1 and remote 0
// - duty writes while running wait in a buffer for the old match
// - buffered duty loads only after three ticks since the write
// - duty writes accepted at any moment and aligned internally
// - carrier mode only on capable instance: low and high widths
// - carrier match: interrupt, clear, toggle carrier, swap compare
// - pin low if slave 0, high if remote 0, carrier if both 1
// - carrier enable is writable master plus read-only slave bit
// - companion event synced, master copied to slave second tick later
// - carrier appears on the pin while counting in carrier mode with the slave and remote bits both high
// - carrier period low plus high plus two, high width high plus one
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "tpc_regs.svh"

module tpc_timer #(
  parameter bit CARRIER_CAPABLE = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // companion counter
  input wire logic companion_period_interrupt,
  // pin and event
  output logic timer_output_pin,
  output logic timer_output_oe,
  output logic timer_match_interrupt
);

  tpc_car_if cif ();

  logic count_run_bit;
  logic out_enable;
  logic output_level_select;
  tpc_pkg::tpc_mode_e mode_sel;
  logic [7:0] cycle_compare_value;
  logic [7:0] duty_compare_value;
  logic [7:0] duty_active;
  logic duty_pending;
  logic [1:0] duty_age;
  logic remote_output_enable;
  logic [7:0] div_limit;
  logic [7:0] div_cnt;
  tpc_pkg::tpc_run_e run_st;
  logic [7:0] counter;
  logic cmp_duty;
  logic carrier_clk;
  logic pwm_active;
  logic next_pin;

  logic counting;
  logic is_pwm;
  logic is_carrier;
  logic [7:0] cmp_val;
  logic match;
  logic duty_wr;

  assign is_pwm = (mode_sel == tpc_pkg::TPC_MODE_PWM);
  assign is_carrier = CARRIER_CAPABLE &&
                      (mode_sel == tpc_pkg::TPC_MODE_CARRIER);
  // run bit gates counting directly so a stop clears the event next clock and the pin the clock after
  assign counting = count_run_bit && (run_st == tpc_pkg::TPC_ST_RUN) &&
                    (is_pwm || is_carrier);
  assign cmp_val = cmp_duty ? duty_active : cycle_compare_value;
  assign match = (counter == cmp_val);
  assign duty_wr = reg_wr && (reg_addr == `TPC_ADDR_DUTY);

  tpc_carrier_ctl u_carrier_ctl (
    .clk(clk),
    .rst_n(rst_n),
    .companion_period_interrupt(companion_period_interrupt),
    .cif(cif.ctl)
  );

  // count clock enable from a divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= `TPC_RST_BYTE;
      cif.count_tick <= 1'b0;
    end else if (div_cnt >= div_limit) begin
      div_cnt <= `TPC_RST_BYTE;
      cif.count_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      cif.count_tick <= 1'b0;
    end
  end

  // mode, cycle, carrier control and divider registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_run_bit <= 1'b0;
      out_enable <= 1'b0;
      output_level_select <= 1'b0;
      mode_sel <= tpc_pkg::TPC_MODE_INTERVAL;
      cycle_compare_value <= `TPC_RST_BYTE;
      remote_output_enable <= 1'b0;
      cif.carrier_enable_master <= 1'b0;
      div_limit <= `TPC_RST_BYTE;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `TPC_ADDR_MODE: begin
          count_run_bit <= reg_wdata[`TPC_MODE_RUN_BIT];
          out_enable <= reg_wdata[`TPC_MODE_OE_BIT];
          output_level_select <= reg_wdata[`TPC_MODE_LEV_BIT];
          mode_sel <= tpc_pkg::tpc_mode_e'(
            reg_wdata[`TPC_MODE_SEL_MSB:`TPC_MODE_SEL_LSB]);
        end
        `TPC_ADDR_CYCLE: begin
          cycle_compare_value <= reg_wdata;
        end
        `TPC_ADDR_CARR: begin
          remote_output_enable <= reg_wdata[`TPC_CARR_REMOTE_BIT];
          // slave bit is read-only, only the master and remote bits take the write
          cif.carrier_enable_master <=
            reg_wdata[`TPC_CARR_MASTER_BIT];
        end
        `TPC_ADDR_DIV: begin
          div_limit <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // run sequencing: the first tick after enable only arms the counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_st <= tpc_pkg::TPC_ST_STOP;
    end else if (!count_run_bit) begin
      run_st <= tpc_pkg::TPC_ST_STOP;
    end else begin
      unique case (run_st)
        tpc_pkg::TPC_ST_STOP: begin
          run_st <= tpc_pkg::TPC_ST_MASK;
        end
        tpc_pkg::TPC_ST_MASK: begin
          if (cif.count_tick) begin
            run_st <= tpc_pkg::TPC_ST_RUN;
          end
        end
        tpc_pkg::TPC_ST_RUN: begin
          run_st <= tpc_pkg::TPC_ST_RUN;
        end
        default: begin
          run_st <= tpc_pkg::TPC_ST_STOP;
        end
      endcase
    end
  end

  // duty (or carrier high width) buffer, loaded at the old value's match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_compare_value <= `TPC_RST_BYTE;
      duty_active <= `TPC_RST_BYTE;
      duty_pending <= 1'b0;
      duty_age <= 2'd0;
    end else if (duty_wr) begin
      duty_compare_value <= reg_wdata;
      if (count_run_bit) begin
        duty_pending <= 1'b1;
        duty_age <= 2'd0;
      end else begin
        duty_active <= reg_wdata;
        duty_pending <= 1'b0;
      end
    end else if (counting && cif.count_tick) begin
      if (cmp_duty && match && duty_pending &&
          duty_age == `TPC_DUTY_LOAD_TICKS) begin
        duty_active <= duty_compare_value;
        duty_pending <= 1'b0;
      end else if (duty_age != `TPC_DUTY_LOAD_TICKS) begin
        duty_age <= duty_age + 2'd1;
      end
    end
  end

  // counter, compare selection and waveform state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      counter <= `TPC_RST_BYTE;
      cmp_duty <= 1'b0;
      carrier_clk <= 1'b0;
      pwm_active <= 1'b0;
      timer_match_interrupt <= 1'b0;
    end else if (!counting) begin
      counter <= `TPC_RST_BYTE;
      cmp_duty <= 1'b0;
      carrier_clk <= 1'b0;
      pwm_active <= 1'b0;
      timer_match_interrupt <= 1'b0;
    end else begin
      timer_match_interrupt <= 1'b0;
      if (cif.count_tick) begin
        if (is_carrier) begin
          if (match) begin
            counter <= `TPC_RST_BYTE;
            timer_match_interrupt <= 1'b1;
            carrier_clk <= ~carrier_clk;
            cmp_duty <= ~cmp_duty;
          end else begin
            counter <= counter + 8'h01;
          end
        end else if (match && !cmp_duty) begin
          counter <= `TPC_RST_BYTE;
          timer_match_interrupt <= 1'b1;
          pwm_active <= 1'b1;
          cmp_duty <= 1'b1;
        end else if (match) begin
          counter <= counter + 8'h01;
          pwm_active <= 1'b0;
          cmp_duty <= 1'b0;
        end else begin
          counter <= counter + 8'h01;
        end
      end
    end
  end

  always_comb begin
    if (is_carrier) begin
      if (!cif.carrier_enable_slave) begin
        next_pin = 1'b0;
      end else if (!remote_output_enable) begin
        next_pin = 1'b1;
      end else begin
        next_pin = carrier_clk;
      end
    end else begin
      next_pin = pwm_active ? output_level_select
                            : ~output_level_select;
    end
  end

  // pin and its enable come from flops so glitches never reach the pad
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_output_pin <= 1'b0;
      timer_output_oe <= 1'b0;
    end else begin
      timer_output_pin <= next_pin;
      timer_output_oe <= out_enable;
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `TPC_RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TPC_ADDR_MODE: begin
          reg_rdata <= {2'b00, mode_sel, 1'b0, output_level_select,
                        out_enable, count_run_bit};
        end
        `TPC_ADDR_CYCLE: begin
          reg_rdata <= cycle_compare_value;
        end
        `TPC_ADDR_DUTY: begin
          reg_rdata <= duty_compare_value;
        end
        `TPC_ADDR_CARR: begin
          reg_rdata <= {5'h00, remote_output_enable,
                        cif.carrier_enable_master, cif.carrier_enable_slave};
        end
        `TPC_ADDR_DIV: begin
          reg_rdata <= div_limit;
        end
        `TPC_ADDR_COUNT: begin
          reg_rdata <= counter;
        end
        `TPC_ADDR_FLAGS: begin
          reg_rdata <= {3'h0, cif.synced_period_pulse, duty_pending,
                        cmp_duty, carrier_clk, pwm_active};
        end
        default: begin
          reg_rdata <= `TPC_RST_BYTE;
        end
      endcase
    end else begin
      reg_rdata <= `TPC_RST_BYTE;
    end
  end

endmodule

`default_nettype wire

// file: verif/tpc_companion.sv
`timescale 1ns/1ns
`default_nettype none

module tpc_companion #(
  parameter int PERIOD = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic en,
  // period event
  output logic companion_period_interrupt
);
  int cnt;

  // a long period keeps the companion far slower than the timer ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      companion_period_interrupt <= 1'b0;
    end else begin
      cnt <= (!en || cnt == PERIOD - 1) ? 0 : cnt + 1;
      companion_period_interrupt <= en && cnt >= PERIOD - 2;
    end
  end
endmodule

`default_nettype wire

// file: verif/tpc_timer_sva.sv
`timescale 1ns/1ns
`default_nettype none
`include "tpc_regs.svh"

module tpc_timer_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // companion counter
  input wire logic companion_period_interrupt,
  // pin and event
  input wire logic timer_output_pin,
  input wire logic timer_output_oe,
  input wire logic timer_match_interrupt
);
  logic [7:0] mode_q;
  logic master_q;
  logic mode_wr;

  assign mode_wr = reg_wr && reg_addr == `TPC_ADDR_MODE;

  // shadow copies, since the checker cannot see inside the block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 8'h00;
    end else if (mode_wr) begin
      mode_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_q <= 1'b0;
    end else if (reg_wr && reg_addr == `TPC_ADDR_CARR) begin
      master_q <= reg_wdata[1];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_pwm_stop;
    mode_wr && reg_wdata[5:4] == 2'h2 && !reg_wdata[0];
  endsequence

  a_reset_quiet: assert property ($rose(rst_n) |->
    !timer_match_interrupt && !timer_output_oe && reg_rdata == 8'h00)
    else $error("outputs not idle after reset");
  a_irq_pulse: assert property (
    timer_match_interrupt |=> !timer_match_interrupt)
    else $error("match event longer than one clock");
  a_irq_needs_run: assert property (timer_match_interrupt |->
    $past(mode_q[0]) && $past(mode_q[5:4]) inside {2'h1, 2'h2})
    else $error("match event without a counting mode");
  a_start_masked: assert property (
    mode_wr && reg_wdata[0] && !mode_q[0] |=> !timer_match_interrupt [*4])
    else $error("match event too soon after start");
  a_stop_quiet: assert property (s_pwm_stop |-> ##2
    !timer_match_interrupt ##1 timer_output_pin == !mode_q[2])
    else $error("stop did not quiet the output");
  a_pwm_rise: assert property (
    timer_match_interrupt && mode_q[5:4] == 2'h2 && mode_q[0]
    |=> timer_output_pin == mode_q[2])
    else $error("pin not active after cycle match");
  a_oe_follow: assert property ($changed(timer_output_oe) |->
    $past(mode_wr) || $past(mode_wr, 2))
    else $error("output enable moved without a mode write");
  a_master_read: assert property (
    $past(reg_rd && reg_addr == `TPC_ADDR_CARR)
    |-> reg_rdata[7:3] == 5'h00 && reg_rdata[1] == master_q)
    else $error("carrier control read back wrong");
endmodule

bind tpc_timer tpc_timer_sva u_tpc_timer_sva (
  .clk(clk),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .companion_period_interrupt(companion_period_interrupt),
  .timer_output_pin(timer_output_pin),
  .timer_output_oe(timer_output_oe),
  .timer_match_interrupt(timer_match_interrupt)
);

`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tpc_regs.svh"

module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic comp_en = 1'b0;
  logic [7:0] reg_rdata;
  logic comp_irq;
  logic pin;
  logic oe;
  logic irq;
  logic [7:0] d;
  int fails = 0;
  int compares = 0;
  int k;
  int per;
  int hi;
  int per2;
  int hi2;
  logic [7:0] ra [8] = '{`TPC_ADDR_CYCLE, `TPC_ADDR_DUTY, `TPC_ADDR_DIV,
    `TPC_ADDR_CARR, `TPC_ADDR_MODE, `TPC_ADDR_COUNT, 8'h20, `TPC_ADDR_FLAGS};
  logic [7:0] rw [8] = '{8'h5a, 8'h3c, 8'h07, 8'h06, 8'h26, 8'hff, 8'hff,
    8'hff};
  logic [7:0] re [8] = '{8'h5a, 8'h3c, 8'h07, 8'h06, 8'h26, 8'h00, 8'h00,
    8'h00};

  always #5 clk = ~clk;

  tpc_timer u_tpc_timer (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .companion_period_interrupt(comp_irq),
    .timer_output_pin(pin), .timer_output_oe(oe),
    .timer_match_interrupt(irq));
  tpc_companion u_tpc_companion (.clk(clk), .rst_n(rst_n), .en(comp_en),
    .companion_period_interrupt(comp_irq));

  task automatic give_verdict();
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask

  task automatic wait_irq();
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (irq !== 1'b1 && k < 500);
    if (irq !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask

  // edges from one match event to the next, with pin-high samples
  task automatic measure();
    per = 0;
    hi = 0;
    do begin
      @(posedge clk);
      per++;
      if (pin === 1'b1) begin
        hi++;
      end
    end while (irq !== 1'b1 && per < 500);
    if (irq !== 1'b1) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic poll_slave(input logic want);
    k = 0;
    do begin
      rd(`TPC_ADDR_CARR, d);
      k++;
    end while (d[0] !== want && k < 50);
    if (d[0] !== want) begin
      fails++;
      give_verdict();
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], d);
      chk(d, 8'h00);
      wr(ra[i], rw[i]);
      rd(ra[i], d);
      chk(d, re[i]);
    end
    wr(`TPC_ADDR_DIV, 8'h00);
    wr(`TPC_ADDR_CYCLE, 8'd20);
    wr(`TPC_ADDR_DUTY, 8'h01);
    wr(`TPC_ADDR_MODE, 8'h27);
    // one clock to arm, one masked tick, 21 ticks, one to register the event
    wait_irq();
    chk(8'(k), 8'd24);
    measure();
    chk(8'(per), 8'd21);
    chk(8'(hi), 8'd2);
    // written just after the old match, so it waits a whole period
    wr(`TPC_ADDR_DUTY, 8'h05);
    wait_irq();
    measure();
    chk(8'(hi), 8'd2);
    measure();
    chk(8'(hi), 8'd6);
    // only two ticks before the old match: too late to load there
    wr(`TPC_ADDR_DUTY, 8'h02);
    measure();
    measure();
    chk(8'(hi), 8'd6);
    measure();
    chk(8'(hi), 8'd3);
    wait_irq();
    wr(`TPC_ADDR_MODE, 8'h26);
    repeat (30) @(posedge clk);
    chk({7'h00, pin}, 8'h00);
    rd(`TPC_ADDR_COUNT, d);
    chk(d, 8'h00);
    wr(`TPC_ADDR_CYCLE, 8'h03);
    wr(`TPC_ADDR_DUTY, 8'h01);
    wr(`TPC_ADDR_CARR, 8'h06);
    comp_en <= 1'b1;
    wr(`TPC_ADDR_MODE, 8'h13);
    // level bit is now 0, so a non-carrier pin would sit high here
    repeat (3) @(posedge clk);
    chk({7'h00, pin}, 8'h00);
    chk({7'h00, oe}, 8'h01);
    poll_slave(1'b1);
    chk(d, 8'h07);
    wait_irq();
    measure();
    per2 = per;
    hi2 = hi;
    measure();
    chk(8'(per + per2), 8'd6);
    chk(8'(per * per2), 8'd8);
    chk(8'(hi + hi2), 8'd2);
    wr(`TPC_ADDR_CARR, 8'h02);
    wait_irq();
    measure();
    chk(8'(hi), 8'(per));
    wr(`TPC_ADDR_CARR, 8'h00);
    poll_slave(1'b0);
    chk(d, 8'h00);
    wait_irq();
    measure();
    chk(8'(hi), 8'h00);
    wr(`TPC_ADDR_MODE, 8'h12);
    // reset after the run bit is cleared while the companion keeps firing
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(`TPC_ADDR_CARR, d);
    chk(d, 8'h00);
    rd(`TPC_ADDR_MODE, d);
    chk(d, 8'h00);
    chk({7'h00, oe}, 8'h00);
    give_verdict();
  end
endmodule

`default_nettype wire
